//--- rtl/ssp_pkg.sv
package ssp_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam logic [7:0] CTRL_OFFSET = 8'h14;
  localparam logic [7:0] DATA_OFFSET = 8'h18;
  localparam logic [7:0] STAT_OFFSET = 8'h1c;
  localparam logic [7:0] MASK_OFFSET = 8'h20;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;
  localparam logic [2:0] IRQ_RESET   = 3'h0;
  localparam int unsigned WRITE_COLLISION_FLAG_POS   = 7;
  localparam int unsigned OVF_POS    = 6;
  localparam int unsigned EN_POS     = 5;
  localparam int unsigned CKP_POS    = 4;
  localparam int unsigned MODE_MSB   = 3;
  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_RX_POS = 0;
  localparam int unsigned IRQ_OV_POS = 1;
  localparam int unsigned IRQ_WC_POS = 2;
  localparam logic [3:0] MODE_M_DIV4  = 4'h0;
  localparam logic [3:0] MODE_M_DIV16 = 4'h1;
  localparam logic [3:0] MODE_M_DIV64 = 4'h2;
  localparam logic [3:0] MODE_M_TMR   = 4'h3;
  localparam logic [3:0] MODE_S_SEL   = 4'h4;
  localparam logic [3:0] MODE_S_FREE  = 4'h5;
  localparam logic [3:0] MODE_I2C_A7  = 4'h6;
  localparam logic [3:0] MODE_I2C_A10 = 4'h7;
  localparam logic [3:0] MODE_I2C_FW  = 4'hb;
  localparam logic [3:0] MODE_I2C_A7I = 4'he;
  localparam logic [3:0] MODE_I2C_A10I = 4'hf;
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_TMR    = 7'h40;
  localparam logic [3:0] LAST_EDGE   = 4'hf;

  typedef enum logic {M_IDLE, M_RUN} master_state_type;

  function automatic logic is_spi_master(input logic [3:0] mode);
    return mode <= MODE_M_TMR;
  endfunction

  function automatic logic is_spi_slave(input logic [3:0] mode);
    return (mode == MODE_S_SEL) || (mode == MODE_S_FREE);
  endfunction

  function automatic logic is_i2c(input logic [3:0] mode);
    return (mode == MODE_I2C_A7) || (mode == MODE_I2C_A10) || (mode == MODE_I2C_FW)
        || (mode == MODE_I2C_A7I) || (mode == MODE_I2C_A10I);
  endfunction

  function automatic logic [6:0] half_period(input logic [3:0] mode);
    return (mode == MODE_M_DIV4) ? HALF_DIV4 : (mode == MODE_M_DIV16) ? HALF_DIV16 :
           (mode == MODE_M_DIV64) ? HALF_DIV64 : HALF_TMR;
  endfunction
endpackage

//--- rtl/link_sync.sv
`timescale 1ns/10ps
`default_nettype none
module link_sync #(
  parameter int unsigned W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Edges only from the second stage onward
  assign o_level = sync_q;
  assign o_rise  = sync_q & ~prev_q;
  assign o_fall  = ~sync_q & prev_q;
endmodule // link_sync
`default_nettype wire

//--- rtl/bit_shifter.sv
`timescale 1ns/10ps
`default_nettype none
module bit_shifter #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_clr,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_data,
  input  wire logic         i_shift,
  input  wire logic         i_bit,
  output logic              o_msb,
  output logic              o_busy,
  output logic              o_done,
  output logic      [W-1:0] o_data
);
  localparam int unsigned CW = $clog2(W + 1);
  localparam logic [CW-1:0] LAST = CW'(W - 1);
  localparam logic [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

  logic [W-1:0]  sr_q;
  logic [CW-1:0] count_q;
  logic          done_q;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || i_clr)
    begin
      sr_q    <= '0;
      count_q <= '0;
      done_q  <= 1'b0;
    end
    else if (i_load)
    begin
      sr_q    <= i_load_data;
      count_q <= '0;
      done_q  <= 1'b0;
    end
    else
    begin
      done_q <= i_shift && (count_q == LAST);
      if (i_shift)
      begin
        sr_q    <= {sr_q[W-2:0], i_bit};
        count_q <= (count_q == LAST) ? '0 : count_q + ONE;
      end
    end
  end

  assign o_msb  = sr_q[W-1];
  assign o_busy = count_q != '0;
  assign o_done = done_q;
  assign o_data = sr_q;
endmodule // bit_shifter
`default_nettype wire

//--- rtl/sync_serial_error_flags.sv
`timescale 1ns/10ps
`default_nettype none
module sync_serial_error_flags
  import ssp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic              i_read,
  input  wire logic              i_write,
  input  wire logic [31:0]       i_writedata,
  output logic      [31:0]       o_readdata,
  output logic                   o_waitrequest,
  input  wire logic              i_sck,
  input  wire logic              i_sdi,
  input  wire logic              i_ss_n,
  output logic                   o_sck,
  output logic                   o_sck_oe_n,
  output logic                   o_sdo,
  output logic                   o_sdo_oe_n,
  output logic                   o_irq
);
  logic             write_collision_flag_q, ovf_q, en_q, ckp_q;
  logic [3:0]       mode_q;
  logic [DATA_W-1:0] buf_q;
  logic             buf_full_q;
  logic [IRQ_W-1:0] stat_q, mask_q, stat_d;
  logic             wait_q;
  logic [31:0]      rdata_q, rdata_d;
  master_state_type mstate_q;
  logic [6:0]       div_q;
  logic [3:0]       edge_cnt_q;
  logic             sck_q, in_bit_q, skip_ack_q;
  logic             sck_oe_n_q, sdo_q, sdo_oe_n_q, irq_q;

  logic [2:0] pin_level, pin_rise, pin_fall;
  logic       sh_msb, sh_busy, sh_done;
  logic [DATA_W-1:0] sh_data;

  link_sync #(.W(3)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_ss_n, i_sdi, i_sck}),
    .o_level   (pin_level),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  wire sck_s  = pin_level[0];
  wire sdi_s  = pin_level[1];
  wire ss_n_s = pin_level[2];
  wire sck_rise = pin_rise[0];
  wire sck_fall = pin_fall[0];
  wire sdi_fall = pin_fall[1];

  // Bus decode
  wire req      = i_read || i_write;
  wire accept   = req && !wait_q;
  wire sel_ctrl = i_address == CTRL_OFFSET;
  wire sel_data = i_address == DATA_OFFSET;
  wire sel_stat = i_address == STAT_OFFSET;
  wire sel_mask = i_address == MASK_OFFSET;
  wire wr_ctrl  = accept && i_write && sel_ctrl;
  wire wr_data  = accept && i_write && sel_data;
  wire wr_stat  = accept && i_write && sel_stat;
  wire wr_mask  = accept && i_write && sel_mask;
  wire rd_data  = accept && i_read && sel_data;
  wire [7:0] ctrl_byte = {write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q};

  // Mode decode
  wire spi_master = en_q && is_spi_master(mode_q);
  wire spi_slave  = en_q && is_spi_slave(mode_q);
  wire i2c_on     = en_q && is_i2c(mode_q);
  wire ss_block   = (mode_q == MODE_S_SEL) && ss_n_s;
  wire m_run      = mstate_q == M_RUN;

  // Master clock generation
  wire tick    = m_run && (div_q == 7'h00);
  wire m_lead  = tick && !edge_cnt_q[0];
  wire m_trail = tick && edge_cnt_q[0];
  wire m_end   = m_trail && (edge_cnt_q == LAST_EDGE);

  // Slave and I2C edges
  wire s_lead    = spi_slave && !ss_block && (ckp_q ? sck_fall : sck_rise);
  wire s_trail   = spi_slave && !ss_block && (ckp_q ? sck_rise : sck_fall);
  wire i2c_start = i2c_on && sdi_fall && sck_s;
  wire i2c_shift = i2c_on && sck_rise && !skip_ack_q && !i2c_start;

  // Write handling; master starts only on a buffer write
  wire busy      = m_run || ((spi_slave || i2c_on) && sh_busy);
  wire col_event = wr_data && busy;
  wire m_start   = wr_data && spi_master && !m_run;
  wire s_load    = wr_data && (spi_slave || i2c_on) && !sh_busy;

  // A ninth I2C clock carries the acknowledge, not data
  wire sh_clr   = !en_q || ss_block || i2c_start || (spi_master && !m_run && !m_start);
  wire sh_shift = m_trail || s_trail || i2c_shift;
  wire sh_bit   = i2c_on ? sdi_s : in_bit_q;

  bit_shifter #(.W(DATA_W)) u_shift (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_clr       (sh_clr),
    .i_load      (m_start || s_load),
    .i_load_data (i_writedata[DATA_W-1:0]),
    .i_shift     (sh_shift),
    .i_bit       (sh_bit),
    .o_msb       (sh_msb),
    .o_busy      (sh_busy),
    .o_done      (sh_done),
    .o_data      (sh_data)
  );

  // Only slave and I2C bytes count; an SPI master transfer leaves the flag alone
  wire unread    = buf_full_q && !rd_data;
  wire ovf_event = sh_done && unread && (spi_slave || i2c_on);
  wire load_buf  = sh_done && !ovf_event;

  assign stat_d = ({col_event, ovf_event, load_buf}) |
                  (stat_q & ~(wr_stat ? i_writedata[IRQ_W-1:0] : IRQ_RESET));

  assign rdata_d = sel_ctrl ? {24'h000000, ctrl_byte} :
                   sel_data ? {24'h000000, buf_q} :
                   sel_stat ? {29'h00000000, stat_q} :
                   sel_mask ? {29'h00000000, mask_q} : 32'h00000000;

  // Control register; a hardware set wins over a software clear
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      {write_collision_flag_q, ovf_q, en_q, ckp_q, mode_q} <= CTRL_RESET;
    end
    else
    begin
      write_collision_flag_q <= col_event || (wr_ctrl ? i_writedata[WRITE_COLLISION_FLAG_POS] : write_collision_flag_q);
      ovf_q  <= ovf_event || (wr_ctrl ? i_writedata[OVF_POS] : ovf_q);
      if (wr_ctrl)
      begin
        en_q   <= i_writedata[EN_POS];
        ckp_q  <= i_writedata[CKP_POS];
        mode_q <= i_writedata[MODE_MSB:0];
      end
    end
  end

  // Data buffer; a read frees it for the next byte
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      buf_q      <= DATA_RESET;
      buf_full_q <= 1'b0;
    end
    else
    begin
      if (load_buf)
      begin
        buf_q <= sh_data;
      end
      buf_full_q <= load_buf || (buf_full_q && !rd_data);
    end
  end

  // Bus slave: one wait cycle, then the answer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      wait_q <= !(req && wait_q);
      if (req && wait_q)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      stat_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
      irq_q  <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      mask_q <= wr_mask ? i_writedata[IRQ_W-1:0] : mask_q;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  // Master sequencer
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mstate_q   <= M_IDLE;
      div_q      <= 7'h00;
      edge_cnt_q <= 4'h0;
      sck_q      <= 1'b0;
    end
    else
    begin
      case (mstate_q)
        M_IDLE:
        begin
          sck_q      <= ckp_q;
          edge_cnt_q <= 4'h0;
          div_q      <= half_period(mode_q) - 7'h01;
          if (m_start)
          begin
            mstate_q <= M_RUN;
          end
        end
        M_RUN:
        begin
          if (!spi_master || m_end)
          begin
            mstate_q <= M_IDLE;
          end
          if (tick)
          begin
            div_q      <= half_period(mode_q) - 7'h01;
            sck_q      <= !sck_q;
            edge_cnt_q <= edge_cnt_q + 4'h1;
          end
          else
          begin
            div_q <= div_q - 7'h01;
          end
        end
        default:
        begin
          mstate_q <= M_IDLE;
        end
      endcase
    end
  end

  // Input bit caught on the leading edge, shifted in on the trailing one
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      in_bit_q   <= 1'b0;
      skip_ack_q <= 1'b0;
    end
    else
    begin
      if (m_lead || s_lead)
      begin
        in_bit_q <= sdi_s;
      end
      if (i2c_start || !i2c_on)
      begin
        skip_ack_q <= 1'b0;
      end
      else if (sh_done)
      begin
        skip_ack_q <= 1'b1;
      end
      else if (sck_rise)
      begin
        skip_ack_q <= 1'b0;
      end
    end
  end

  // Pin outputs; enables are low while driving
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      sck_oe_n_q <= 1'b1;
      sdo_q      <= 1'b0;
      sdo_oe_n_q <= 1'b1;
    end
    else
    begin
      sck_oe_n_q <= !spi_master;
      sdo_q      <= sh_msb;
      sdo_oe_n_q <= !(spi_master || (spi_slave && !ss_block));
    end
  end

  assign o_readdata    = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_sck         = sck_q;
  assign o_sck_oe_n    = sck_oe_n_q;
  assign o_sdo         = sdo_q;
  assign o_sdo_oe_n    = sdo_oe_n_q;
  assign o_irq         = irq_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_slave_ovf;
    sh_done && spi_slave && buf_full_q && !rd_data;
  endsequence

  sequence s_i2c_ovf;
    sh_done && i2c_on && buf_full_q && !rd_data;
  endsequence

  sequence s_bus_answer;
    !o_waitrequest ##1 o_waitrequest;
  endsequence

  AST_CTRL_RESET: assert property ($fell(i_sys_rst) |-> ctrl_byte == 8'h00)
    else $error("control register not zero after reset");
  AST_SPI_OVF_SET: assert property (s_slave_ovf |=> ovf_q && stat_q[IRQ_OV_POS])
    else $error("spi overflow not flagged");
  AST_OVF_KEEPS_BUF: assert property (ovf_event |=> $stable(buf_q) && buf_full_q)
    else $error("buffer changed on overflow");
  AST_MASTER_NO_OVF: assert property (spi_master && !wr_ctrl && !ovf_q |=> !ovf_q)
    else $error("overflow set in master mode");
  AST_MASTER_START: assert property (m_start |=> m_run ##1 (sck_q == $past(sck_q)))
    else $error("master transfer not started by buffer write");
  AST_I2C_OVF_SET: assert property (s_i2c_ovf |=> ovf_q)
    else $error("i2c overflow not flagged");
  AST_OVF_STICKY: assert property (ovf_q && !wr_ctrl |=> ovf_q)
    else $error("overflow cleared by hardware");
  AST_WRITE_COLLISION_FLAG_SET: assert property (col_event |=> write_collision_flag_q && stat_q[IRQ_WC_POS])
    else $error("collision not flagged");
  AST_WRITE_COLLISION_FLAG_STICKY: assert property (write_collision_flag_q && !wr_ctrl |=> write_collision_flag_q)
    else $error("collision cleared by hardware");
  AST_BUS_ANSWER: assert property (req && wait_q |=> s_bus_answer)
    else $error("bus answer not one cycle after request");
endmodule // sync_serial_error_flags
`default_nettype wire

//--- verification/spi_peer_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
  output logic o_sck,
  output logic o_sdi,
  output logic o_ss_n
);
  initial
  begin
    o_sck = 1'b0;
    o_sdi = 1'b1;
    o_ss_n = 1'b1;
  end

  // Link master, 160 ns period; clock stands still between frames
  task automatic spi_byte(input logic [7:0] b);
    o_ss_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      o_sdi = b[i];
      #80 o_sck = 1'b1;
      #80 o_sck = 1'b0;
    end
    // Released line shows the inverse, so a stale bit cannot pass
    o_sdi = ~o_sdi;
    o_ss_n = 1'b1;
    #80;
  endtask

  // Pull-ups: both lines high when idle
  task automatic bus_idle_high();
    o_sck = 1'b1;
    o_sdi = 1'b1;
    #160;
  endtask

  task automatic i2c_byte(input logic [7:0] b);
    o_sdi = 1'b0;
    #80 o_sck = 1'b0;
    for (int i = 8; i >= 0; i--)
    begin
      // Ninth clock: data released high for acknowledge
      o_sdi = (i == 0) ? 1'b1 : b[i-1];
      #40 o_sck = 1'b1;
      #80 o_sck = 1'b0;
      #40;
    end
    o_sdi = 1'b0;
    #40 o_sck = 1'b1;
    #40 o_sdi = 1'b1;
    #80;
  endtask
endmodule // spi_peer_model
`default_nettype wire

//--- verification/sync_serial_error_flags_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module sync_serial_error_flags_tb_top
  import ssp_pkg::*;
;
  logic              i_clk;
  logic              i_sys_rst;
  logic [ADDR_W-1:0] i_address;
  logic              i_read;
  logic              i_write;
  logic [31:0]       i_writedata;
  logic [31:0]       o_readdata;
  logic              o_waitrequest;
  logic              o_sck;
  logic              o_sck_oe_n;
  logic              o_sdo;
  logic              o_sdo_oe_n;
  logic              o_irq;
  wire               sck_w;
  wire               sdi_w;
  wire               ss_n_w;
  int                err_count;
  int                n_compared;
  logic [31:0]       exp_q[$];
  logic [7:0]        b0;
  logic [7:0]        b1;
  logic [7:0]        b2;

  sync_serial_error_flags u_sync_serial_error_flags (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_sck(sck_w), .i_sdi(sdi_w), .i_ss_n(ss_n_w),
    .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n),
    .o_irq(o_irq)
  );

  spi_peer_model u_spi_peer_model (
    .o_sck(sck_w),
    .o_sdi(sdi_w),
    .o_ss_n(ss_n_w)
  );

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data taken at the edge that completes the read
  always @(posedge i_clk)
  begin
    if (i_read === 1'b1 && o_waitrequest === 1'b0 && exp_q.size() > 0)
      chk(o_readdata, exp_q.pop_front());
  end

  task automatic bus(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_address <= a;
    i_read <= ~w;
    i_write <= w;
    i_writedata <= d;
    // Request stands until the rising edge that sees waitrequest low
    do
    begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      err_count++;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic irq_is(input logic e);
    settle(3);
    @(negedge i_clk);
    chk({31'h0, o_irq}, {31'h0, e});
  endtask

  // Pin order: sck, sck enable, data out, data enable
  task automatic pins_are(input logic [3:0] e);
    @(negedge i_clk);
    chk({28'h0, o_sck, o_sck_oe_n, o_sdo, o_sdo_oe_n}, {28'h0, e});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end

  initial
  begin
    i_sys_rst = 1'b1;
    i_address = '0;
    i_read = 1'b0;
    i_write = 1'b0;
    i_writedata = 32'h0;
    err_count = 0;
    n_compared = 0;
    void'($urandom(72));
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    b2 = 8'($urandom);
    // Overflow check needs the dropped byte to differ from the kept one
    if (b2 == b1)
      b2 = ~b1;
    settle(10);
    i_sys_rst <= 1'b0;
    rd(CTRL_OFFSET, {24'h0, CTRL_RESET});
    wr(CTRL_OFFSET, 32'hff);
    rd(CTRL_OFFSET, 32'hff);
    rd(8'h30, 32'h0);
    // Slave, free select, polarity 0
    wr(CTRL_OFFSET, 32'h25);
    u_spi_peer_model.spi_byte(b0);
    settle(8);
    rd(DATA_OFFSET, {24'h0, b0});
    u_spi_peer_model.spi_byte(b1);
    u_spi_peer_model.spi_byte(b2);
    settle(8);
    rd(CTRL_OFFSET, 32'h65);
    rd(DATA_OFFSET, {24'h0, b1});
    rd(STAT_OFFSET, 32'h3);
    wr(MASK_OFFSET, 32'h0);
    irq_is(1'b0);
    wr(MASK_OFFSET, 32'h2);
    irq_is(1'b1);
    rd(CTRL_OFFSET, 32'h65);
    wr(STAT_OFFSET, 32'h7);
    irq_is(1'b0);
    wr(CTRL_OFFSET, 32'h25);
    rd(CTRL_OFFSET, 32'h25);
    // Master: a second write lands mid-transfer
    wr(CTRL_OFFSET, 32'h20);
    settle(2);
    pins_are(4'h0);
    wr(DATA_OFFSET, {24'h0, b0});
    wr(DATA_OFFSET, {24'h0, b1});
    rd(CTRL_OFFSET, 32'ha0);
    settle(40);
    rd(CTRL_OFFSET, 32'ha0);
    wr(CTRL_OFFSET, 32'h20);
    wr(DATA_OFFSET, {24'h0, b2});
    settle(1);
    pins_are({2'b00, b2[7], 1'b0});
    settle(40);
    wr(DATA_OFFSET, {24'h0, b0});
    settle(40);
    rd(CTRL_OFFSET, 32'h20);
    // Receive-only bus mode; buffer emptied first
    u_spi_peer_model.bus_idle_high();
    wr(CTRL_OFFSET, 32'h26);
    settle(1);
    pins_are(4'h5);
    bus(DATA_OFFSET, 1'b0, 32'h0);
    u_spi_peer_model.i2c_byte(b0);
    settle(8);
    rd(DATA_OFFSET, {24'h0, b0});
    u_spi_peer_model.i2c_byte(b1);
    u_spi_peer_model.i2c_byte(b2);
    settle(8);
    rd(CTRL_OFFSET, 32'h66);
    rd(DATA_OFFSET, {24'h0, b1});
    settle(4);
    wrap_up();
  end
endmodule // sync_serial_error_flags_tb_top
`default_nettype wire
